// File: core/mas_pkg.sv
// Package: constants, register layout and types for the MOVX steering block
package mas_pkg;

    // ------------------------------------------------------------------
    // Register addresses on the special function register port
    // ------------------------------------------------------------------
    localparam logic [7:0] MAS_ADDR_PROGRAM_STORE_CONTROL_REG = 8'h8F; // program_store_control
    localparam logic [7:0] MAS_ADDR_FLASH_TIMING_CONTROL_REG = 8'hB6; // flash_timing_control
    localparam logic [7:0] MAS_ADDR_PAGE_REG  = 8'hA2; // ext_page_select
    localparam logic [7:0] MAS_ADDR_CFG_REG   = 8'hA3; // ext_mem_config
    localparam logic [7:0] MAS_ADDR_DPL_REG   = 8'h82; // data pointer low
    localparam logic [7:0] MAS_ADDR_DPH_REG   = 8'h83; // data pointer high

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] MAS_RST_PROGRAM_STORE_CONTROL = 8'h00;
    localparam logic [7:0] MAS_RST_FLASH_TIMING_CONTROL = 8'h80;
    localparam logic [7:0] MAS_RST_PAGE  = 8'h00;
    localparam logic [7:0] MAS_RST_CFG   = 8'h03;
    localparam logic [7:0] MAS_RST_DP    = 8'h00;
    localparam logic [7:0] MAS_ZERO_BYTE = 8'h00;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int MAS_FL_ONESHOT_BIT   = 7;
    localparam int MAS_FL_RDALWAYS_BIT  = 6;
    localparam int MAS_FL_WREN_BIT      = 0;
    localparam int MAS_PS_SCRATCH_BIT   = 2;
    localparam int MAS_PS_ERASE_BIT     = 1;
    localparam int MAS_PS_WRITE_BIT     = 0;
    localparam int MAS_CFG_BANK_BIT     = 5;
    localparam int MAS_CFG_MUX_BIT      = 4;
    localparam int MAS_CFG_MODE_HI      = 3;
    localparam int MAS_CFG_MODE_LO      = 2;
    localparam int MAS_CFG_ALE_HI       = 1;
    localparam int MAS_CFG_ALE_LO       = 0;
    localparam int MAS_CFG_WIDTH        = 6;

    // ------------------------------------------------------------------
    // Memory map
    // ------------------------------------------------------------------
    localparam int          MAS_XRAM_AW       = 12;   // 4 kB on-chip RAM
    localparam logic [15:0] MAS_ONCHIP_LIMIT  = 16'h1000;
    localparam int          MAS_SCRATCH_AW    = 7;    // 128-byte sector
    localparam int          MAS_PAGE_AW       = 9;    // flash page offset bits

    // Memory mode field encodings
    localparam logic [1:0] MAS_MODE_ONCHIP   = 2'h0;
    localparam logic [1:0] MAS_MODE_SPLIT_NB = 2'h1;
    localparam logic [1:0] MAS_MODE_SPLIT_B  = 2'h2;
    localparam logic [1:0] MAS_MODE_OFFCHIP  = 2'h3;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int         MAS_CLK_PERIOD_NS  = 10;
    localparam int         MAS_STROBE_NS      = 40;
    localparam logic [3:0] MAS_STROBE_CYCLES  =
        4'((MAS_STROBE_NS + MAS_CLK_PERIOD_NS - 1) / MAS_CLK_PERIOD_NS);

    typedef enum logic [2:0] {
        MAS_ST_IDLE   = 3'b000,
        MAS_ST_RAM    = 3'b001,
        MAS_ST_RAMRD  = 3'b010,
        MAS_ST_ALE_HI = 3'b011,
        MAS_ST_ALE_LO = 3'b100,
        MAS_ST_STROBE = 3'b101
    } mas_state_type;

endpackage : mas_pkg

// File: core/mas_ram_if.sv
// Interface: port between the steering logic and the on-chip data RAM
`timescale 1ns/10ps
interface mas_ram_if #(parameter int AW = 12);
    logic          en;
    logic          we;
    logic [AW-1:0] addr;
    logic [7:0]    wdata;
    logic [7:0]    rdata;

    modport ctrl (output en, output we, output addr, output wdata,
                  input rdata);
    modport mem  (input en, input we, input addr, input wdata,
                  output rdata);
endinterface : mas_ram_if

// File: core/mas_top.sv
// Module: MOVX access steering, flash control registers and memory interface
//
// Summary of operation
// - Flash timing reserved bits 5-1 read zero.
// - Flash write/erase blocked unless enable bit set.
// - Scratchpad select redirects flash access to 128 bytes.
// - Erase plus write enable: write erases page.
// - Page holding security bytes never software-erased.
// - Write enable sends writes to flash, else RAM.
// - Program store bits 7-3 read zero.
// - 4 kB on-chip RAM mapped into data space.
// - 8-bit form: page register high, index low.
// - 16-bit form uses data pointer, byte-accessible.
// - Without flash redirection, moves access data space.
// - Port select bit picks lower or upper ports.
// - Pins driven only during off-chip move.
// - Input pins undriven during move, e.g. reads.
// - Pin output modes untouched by interface activity.
// - Two-bit field selects one of four memory modes.
// - Mux bit: zero multiplexed, one separate pins.
`timescale 1ns/10ps
module mas_top
    import mas_pkg::*;
#(
    parameter logic [15-MAS_PAGE_AW:0] LOCK_PAGE = '1 // security-byte page
)(
    input  wire logic        CORE_CLK,
    input  wire logic        RST,
    // Register port
    input  wire logic [7:0]  SFR_ADDR,
    input  wire logic        SFR_WR,
    input  wire logic        SFR_RD,
    input  wire logic [7:0]  SFR_WDATA,
    output logic      [7:0]  SFR_RDATA,
    // Move request from the core
    input  wire logic        MX_REQ,
    input  wire logic        MX_WRITE,
    input  wire logic        MX_WIDE,
    input  wire logic [7:0]  MX_INDEX,
    input  wire logic [7:0]  MX_WDATA,
    output logic             MX_DONE,
    output logic      [7:0]  MX_RDATA,
    // Flash controller
    output logic             FL_WR,
    output logic             FL_ERASE,
    output logic      [15:0] FL_ADDR,
    output logic      [7:0]  FL_WDATA,
    output logic             FL_SCRATCH,
    output logic             FL_ONESHOT,
    output logic             FL_RDALWAYS,
    // External memory pins
    output logic             PORT_BANK_HIGH,
    output logic      [7:0]  ADDR_HI_OUT,
    output logic             ADDR_HI_OE,
    output logic      [7:0]  ADDR_LO_OUT,
    output logic             ADDR_LO_OE,
    input  wire logic [7:0]  DATA_IN,
    output logic      [7:0]  DATA_OUT,
    output logic             DATA_OE,
    output logic             WR_N,
    output logic             RD_N,
    output logic             ALE,
    output logic             CTRL_OE
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        mas_state_type          st;
        logic                   flash_oneshot_enable;
        logic                   flash_read_always;
        logic                   flash_wr_erase_enable;
        logic                   scratchpad_select;
        logic                   page_erase_enable;
        logic                   program_write_enable;
        logic [7:0]             ext_page_select;
        logic [MAS_CFG_WIDTH-1:0] ext_mem_config;
        logic [7:0]             dph;
        logic [7:0]             dpl;
        logic [7:0]             sfr_rdata;
        logic [3:0]             cnt;
        logic [15:0]            addr;
        logic [7:0]             wdata;
        logic                   write;
        logic                   mx_done;
        logic [7:0]             mx_rdata;
        logic                   ram_en;
        logic                   ram_we;
        logic [MAS_XRAM_AW-1:0] ram_addr;
        logic [7:0]             ram_wdata;
        logic                   fl_wr;
        logic                   fl_erase;
        logic [15:0]            fl_addr;
        logic [7:0]             fl_wdata;
        logic [7:0]             a_hi;
        logic                   a_hi_oe;
        logic [7:0]             a_lo;
        logic                   a_lo_oe;
        logic [7:0]             d_out;
        logic                   d_oe;
        logic                   wr_n;
        logic                   rd_n;
        logic                   ale;
        logic                   ctl_oe;
        logic [7:0]             din_s1;
        logic [7:0]             din_s2;
    } mas_regs_type;

    mas_regs_type r;
    mas_regs_type next_r;

    mas_ram_if #(.AW(MAS_XRAM_AW)) ram_bus ();

    mas_xram #(.AW(MAS_XRAM_AW)) u_xram (
        .CORE_CLK (CORE_CLK),
        .ram      (ram_bus)
    );

    assign ram_bus.en    = r.ram_en;
    assign ram_bus.we    = r.ram_we;
    assign ram_bus.addr  = r.ram_addr;
    assign ram_bus.wdata = r.ram_wdata;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [15:0] eff_addr(input logic       wide,
                                             input logic [7:0] hi,
                                             input logic [7:0] lo,
                                             input logic [7:0] page,
                                             input logic [7:0] index);
        eff_addr = wide ? {hi, lo} : {page, index};
    endfunction : eff_addr

    function automatic logic goes_onchip(input logic [1:0]  mode,
                                         input logic [15:0] a);
        case (mode)
            MAS_MODE_ONCHIP:  goes_onchip = 1'b1;
            MAS_MODE_OFFCHIP: goes_onchip = 1'b0;
            default:          goes_onchip = (a < MAS_ONCHIP_LIMIT);
        endcase
    endfunction : goes_onchip

    function automatic logic [3:0] phase_len(input logic [1:0] sel);
        phase_len = {2'h0, sel};    // Field value N gives N+1 cycles
    endfunction : phase_len

    logic [1:0]  mode;
    logic        muxed;
    logic [15:0] req_addr;
    assign mode     = r.ext_mem_config[MAS_CFG_MODE_HI:MAS_CFG_MODE_LO];
    assign muxed    = ~r.ext_mem_config[MAS_CFG_MUX_BIT];
    assign req_addr = eff_addr(MX_WIDE, r.dph, r.dpl, r.ext_page_select,
                               MX_INDEX);

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        next_r          = r;
        next_r.mx_done  = 1'b0;
        next_r.fl_wr    = 1'b0;
        next_r.fl_erase = 1'b0;
        next_r.din_s1   = DATA_IN;
        next_r.din_s2   = r.din_s1;

        // Register writes
        if (SFR_WR) begin
            case (SFR_ADDR)
                MAS_ADDR_FLASH_TIMING_CONTROL_REG: begin
                    next_r.flash_oneshot_enable  =
                        SFR_WDATA[MAS_FL_ONESHOT_BIT];
                    next_r.flash_read_always     =
                        SFR_WDATA[MAS_FL_RDALWAYS_BIT];
                    next_r.flash_wr_erase_enable =
                        SFR_WDATA[MAS_FL_WREN_BIT];
                end
                MAS_ADDR_PROGRAM_STORE_CONTROL_REG: begin
                    next_r.scratchpad_select    =
                        SFR_WDATA[MAS_PS_SCRATCH_BIT];
                    next_r.page_erase_enable    =
                        SFR_WDATA[MAS_PS_ERASE_BIT];
                    next_r.program_write_enable =
                        SFR_WDATA[MAS_PS_WRITE_BIT];
                end
                MAS_ADDR_PAGE_REG: next_r.ext_page_select = SFR_WDATA;
                MAS_ADDR_CFG_REG:
                    next_r.ext_mem_config = SFR_WDATA[MAS_CFG_WIDTH-1:0];
                MAS_ADDR_DPL_REG:  next_r.dpl = SFR_WDATA;
                MAS_ADDR_DPH_REG:  next_r.dph = SFR_WDATA;
                default: ;
            endcase
        end

        // Register reads; unused and reserved bits read zero
        if (SFR_RD) begin
            case (SFR_ADDR)
                MAS_ADDR_FLASH_TIMING_CONTROL_REG:
                    next_r.sfr_rdata = {r.flash_oneshot_enable,
                                        r.flash_read_always, 5'h00,
                                        r.flash_wr_erase_enable};
                MAS_ADDR_PROGRAM_STORE_CONTROL_REG:
                    next_r.sfr_rdata = {5'h00, r.scratchpad_select,
                                        r.page_erase_enable,
                                        r.program_write_enable};
                MAS_ADDR_PAGE_REG: next_r.sfr_rdata = r.ext_page_select;
                MAS_ADDR_CFG_REG:
                    next_r.sfr_rdata = {2'h0, r.ext_mem_config};
                MAS_ADDR_DPL_REG:  next_r.sfr_rdata = r.dpl;
                MAS_ADDR_DPH_REG:  next_r.sfr_rdata = r.dph;
                default:           next_r.sfr_rdata = MAS_ZERO_BYTE;
            endcase
        end

        case (r.st)
            MAS_ST_IDLE: begin
                if (MX_REQ) begin
                    next_r.addr  = req_addr;
                    next_r.wdata = MX_WDATA;
                    next_r.write = MX_WRITE;
                    if (MX_WRITE && r.program_write_enable) begin
                        next_r.mx_done = 1'b1;
                        // Blocked attempts finish silently
                        if (r.flash_wr_erase_enable) begin
                            next_r.fl_wdata = MX_WDATA;
                            next_r.fl_addr  = r.scratchpad_select ?
                                {{(16-MAS_SCRATCH_AW){1'b0}},
                                 req_addr[MAS_SCRATCH_AW-1:0]} :
                                req_addr;
                            if (r.page_erase_enable) begin
                                next_r.fl_erase = r.scratchpad_select ||
                                    (req_addr[15:MAS_PAGE_AW] !=
                                     LOCK_PAGE);
                            end else begin
                                next_r.fl_wr = 1'b1;
                            end
                        end
                    end else if (goes_onchip(mode, req_addr)) begin
                        // Mode 00 aliases on 4k boundaries
                        next_r.ram_en    = 1'b1;
                        next_r.ram_we    = MX_WRITE;
                        next_r.ram_addr  = req_addr[MAS_XRAM_AW-1:0];
                        next_r.ram_wdata = MX_WDATA;
                        next_r.st        = MAS_ST_RAM;
                    end else begin
                        // Pins claimed only for the off-chip move
                        // Without bank select the 8-bit form leaves the
                        // high address to the port latches
                        next_r.a_hi    = req_addr[15:8];
                        next_r.a_hi_oe = MX_WIDE ||
                                         (mode == MAS_MODE_SPLIT_B);
                        next_r.ctl_oe  = 1'b1;
                        next_r.wr_n    = 1'b1;
                        next_r.rd_n    = 1'b1;
                        next_r.cnt = phase_len(
                            r.ext_mem_config[MAS_CFG_ALE_HI:MAS_CFG_ALE_LO]);
                        if (muxed) begin
                            next_r.d_out = req_addr[7:0];
                            next_r.d_oe  = 1'b1;
                            next_r.ale   = 1'b1;
                            next_r.st    = MAS_ST_ALE_HI;
                        end else begin
                            next_r.a_lo    = req_addr[7:0];
                            next_r.a_lo_oe = 1'b1;
                            next_r.st      = MAS_ST_ALE_LO;
                        end
                    end
                end
            end
            MAS_ST_RAM: begin
                next_r.ram_en = 1'b0;
                next_r.st     = MAS_ST_RAMRD;
            end
            MAS_ST_RAMRD: begin
                if (!r.write) begin
                    next_r.mx_rdata = ram_bus.rdata;
                end
                next_r.mx_done = 1'b1;
                next_r.st      = MAS_ST_IDLE;
            end
            MAS_ST_ALE_HI: begin
                if (r.cnt == 4'h0) begin
                    next_r.ale = 1'b0;
                    next_r.cnt = phase_len(
                        r.ext_mem_config[MAS_CFG_ALE_HI:MAS_CFG_ALE_LO]);
                    next_r.st  = MAS_ST_ALE_LO;
                end else begin
                    next_r.cnt = r.cnt - 4'h1;
                end
            end
            MAS_ST_ALE_LO: begin
                if (r.cnt == 4'h0) begin
                    next_r.cnt   = MAS_STROBE_CYCLES;
                    next_r.d_out = r.wdata;
                    next_r.d_oe  = r.write;    // Data pins driven for writes only
                    next_r.wr_n  = ~r.write;
                    next_r.rd_n  = r.write;
                    next_r.st    = MAS_ST_STROBE;
                end else begin
                    next_r.cnt = r.cnt - 4'h1;
                end
            end
            MAS_ST_STROBE: begin
                if (r.cnt == 4'h0) begin
                    // Sampled through the two-stage synchroniser, so the
                    // strobe must outlast the synchroniser delay
                    if (!r.write) begin
                        next_r.mx_rdata = r.din_s2;
                    end
                    next_r.mx_done = 1'b1;
                    next_r.wr_n    = 1'b1;
                    next_r.rd_n    = 1'b1;
                    next_r.d_oe    = 1'b0;
                    next_r.a_hi_oe = 1'b0;
                    next_r.a_lo_oe = 1'b0;
                    next_r.ctl_oe  = 1'b0;
                    next_r.st      = MAS_ST_IDLE;
                end else begin
                    next_r.cnt = r.cnt - 4'h1;
                end
            end
            default: next_r.st = MAS_ST_IDLE;
        endcase
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            r                       <= '0;
            r.st                    <= MAS_ST_IDLE;
            r.flash_oneshot_enable  <= MAS_RST_FLASH_TIMING_CONTROL[MAS_FL_ONESHOT_BIT];
            r.flash_read_always     <= MAS_RST_FLASH_TIMING_CONTROL[MAS_FL_RDALWAYS_BIT];
            r.flash_wr_erase_enable <= MAS_RST_FLASH_TIMING_CONTROL[MAS_FL_WREN_BIT];
            r.scratchpad_select     <= MAS_RST_PROGRAM_STORE_CONTROL[MAS_PS_SCRATCH_BIT];
            r.page_erase_enable     <= MAS_RST_PROGRAM_STORE_CONTROL[MAS_PS_ERASE_BIT];
            r.program_write_enable  <= MAS_RST_PROGRAM_STORE_CONTROL[MAS_PS_WRITE_BIT];
            r.ext_page_select       <= MAS_RST_PAGE;
            r.ext_mem_config        <= MAS_RST_CFG[MAS_CFG_WIDTH-1:0];
            r.dph                   <= MAS_RST_DP;
            r.dpl                   <= MAS_RST_DP;
            r.wr_n                  <= 1'b1;
            r.rd_n                  <= 1'b1;
        end else begin
            r <= next_r;
        end
    end

    // ------------------------------------------------------------------
    // Outputs; push-pull or open-drain choice lives in the port
    // output-mode registers and is never touched here
    // ------------------------------------------------------------------
    assign SFR_RDATA      = r.sfr_rdata;
    assign MX_DONE        = r.mx_done;
    assign MX_RDATA       = r.mx_rdata;
    assign FL_WR          = r.fl_wr;
    assign FL_ERASE       = r.fl_erase;
    assign FL_ADDR        = r.fl_addr;
    assign FL_WDATA       = r.fl_wdata;
    assign FL_SCRATCH     = r.scratchpad_select;
    assign FL_ONESHOT     = r.flash_oneshot_enable;
    assign FL_RDALWAYS    = r.flash_read_always;
    assign PORT_BANK_HIGH = r.ext_mem_config[MAS_CFG_BANK_BIT];
    assign ADDR_HI_OUT    = r.a_hi;
    assign ADDR_HI_OE     = r.a_hi_oe;
    assign ADDR_LO_OUT    = r.a_lo;
    assign ADDR_LO_OE     = r.a_lo_oe;
    assign DATA_OUT       = r.d_out;
    assign DATA_OE        = r.d_oe;
    assign WR_N           = r.wr_n;
    assign RD_N           = r.rd_n;
    assign ALE            = r.ale;
    assign CTRL_OE        = r.ctl_oe;

endmodule : mas_top

// File: core/mas_xram.sv
// Module: on-chip data RAM with registered read data
`timescale 1ns/10ps
module mas_xram
    import mas_pkg::*;
#(
    parameter int AW = MAS_XRAM_AW
)(
    input wire logic CORE_CLK,
    mas_ram_if.mem   ram
);
    logic [7:0] mem_array [0:(1<<AW)-1];
    logic [7:0] rdata_q;

    always_ff @(posedge CORE_CLK) begin
        if (ram.en) begin
            if (ram.we) begin
                mem_array[ram.addr] <= ram.wdata;
            end
            rdata_q <= mem_array[ram.addr];
        end
    end

    assign ram.rdata = rdata_q;
endmodule : mas_xram

// File: sim/mas_props.sv
// Checker: register and pin timing relations of the steering block
`timescale 1ns/10ps
module mas_props
    import mas_pkg::*;
(
    input wire logic       CORE_CLK, RST, SFR_RD, MX_DONE, FL_WR,
    input wire logic       FL_ERASE, FL_ONESHOT, DATA_OE, CTRL_OE, WR_N,
    input wire logic       RD_N,
    input wire logic [7:0] SFR_ADDR, SFR_RDATA
);
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (RST);
    // Strobe low for five cycles, then released
    sequence s_strobe;
        !WR_N [*5] ##1 WR_N;
    endsequence
    a_flash_timing_control_reserved:
    assert property (SFR_RD && SFR_ADDR == MAS_ADDR_FLASH_TIMING_CONTROL_REG
        |=> SFR_RDATA[5:1] == 5'h00) else $error("flash timing bits set");
    a_program_store_control_unused:
    assert property (SFR_RD && SFR_ADDR == MAS_ADDR_PROGRAM_STORE_CONTROL_REG
        |=> SFR_RDATA[7:3] == 5'h00) else $error("store control bits set");
    a_pins_released:
    assert property (MX_DONE |-> !CTRL_OE && !DATA_OE)
        else $error("pins held after move");
    a_read_undriven:
    assert property (!RD_N |-> !DATA_OE) else $error("data driven on read");
    a_program_done:
    assert property (FL_WR |-> MX_DONE && !FL_ERASE)
        else $error("program pulse out of step");
    a_erase_done:
    assert property (FL_ERASE |-> MX_DONE) else $error("erase out of step");
    a_oneshot_reset:
    assert property ($past(RST) |-> FL_ONESHOT) else $error("oneshot reset");
    a_strobe_len:
    assert property ($fell(WR_N) |-> s_strobe) else $error("strobe length");
endmodule : mas_props

bind mas_top mas_props u_mas_props (.CORE_CLK(CORE_CLK), .RST(RST),
    .SFR_RD(SFR_RD), .MX_DONE(MX_DONE), .FL_WR(FL_WR),
    .FL_ERASE(FL_ERASE), .FL_ONESHOT(FL_ONESHOT), .DATA_OE(DATA_OE),
    .CTRL_OE(CTRL_OE), .WR_N(WR_N), .RD_N(RD_N), .SFR_ADDR(SFR_ADDR),
    .SFR_RDATA(SFR_RDATA));

// File: sim/mas_sram_model.sv
// Partner: byte-wide off-chip RAM behind a multiplexed address latch
`timescale 1ns/10ps
module mas_sram_model (
    input wire logic       CORE_CLK, ALE, WR_N, RD_N,
    input wire logic [7:0] AD_OUT,
    output logic     [7:0] AD_IN
);
    logic [7:0] mem [256];
    logic [7:0] lat = 8'h00;
    logic [7:0] last = 8'h00;
    always @(posedge CORE_CLK) begin
        if (ALE) lat <= AD_OUT;
        if (!WR_N) mem[lat] <= AD_OUT;
        if (!RD_N) last <= mem[lat];
    end
    // Released bus shows the inverse, so a stale value never matches
    assign AD_IN = !RD_N ? mem[lat] : ~last;
endmodule : mas_sram_model

// File: sim/mas_top_tb.sv
// Testbench: registers, flash steering, on-chip and off-chip moves
`timescale 1ns/10ps
module mas_top_tb;
    import mas_pkg::*;
    logic CORE_CLK = 1'b0, RST = 1'b1, SFR_WR = 1'b0, SFR_RD = 1'b0;
    logic MX_REQ = 1'b0, MX_WRITE = 1'b0, MX_WIDE = 1'b0, rd_d = 1'b0;
    logic [7:0] SFR_ADDR = 8'h00, SFR_WDATA = 8'h00, MX_INDEX = 8'h00;
    logic [7:0] MX_WDATA = 8'h00, DATA_IN, SFR_RDATA, MX_RDATA, FL_WDATA;
    logic [7:0] ADDR_HI_OUT, ADDR_LO_OUT, DATA_OUT, last = 8'h00, v;
    logic [15:0] FL_ADDR;
    logic MX_DONE, FL_WR, FL_ERASE, FL_SCRATCH, FL_ONESHOT, FL_RDALWAYS;
    logic PORT_BANK_HIGH, ADDR_HI_OE, ADDR_LO_OE, DATA_OE, WR_N, RD_N;
    logic ALE, CTRL_OE;
    logic [9:0] notes [$];
    logic [24:0] fl_notes [$];
    logic [24:0] fl_exp;
    logic [31:0] seed = 32'hE10F;
    int fail_count = 0, comparisons = 0;
    mas_top u_mas_top (.*);
    mas_sram_model u_mas_sram_model (.CORE_CLK(CORE_CLK), .ALE(ALE),
        .WR_N(WR_N), .RD_N(RD_N), .AD_OUT(DATA_OUT), .AD_IN(DATA_IN));
    always #5 CORE_CLK = ~CORE_CLK;
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction : xs
    task automatic conclude;
        if (fail_count == 0 && comparisons > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : conclude
    task automatic check(input string what, input logic [9:0] seen);
        logic [9:0] exp;
        exp = notes.pop_front();
        comparisons++;
        if (exp !== seen) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    // A read notes its expected value; a write stores d
    task automatic sfr(input logic rd, input logic [7:0] a, d);
        if (rd) notes.push_back({2'b00, d});
        @(posedge CORE_CLK);
        SFR_ADDR <= a;
        SFR_WDATA <= d;
        SFR_RD <= rd;
        SFR_WR <= !rd;
        @(posedge CORE_CLK);
        SFR_RD <= 1'b0;
        SFR_WR <= 1'b0;
    endtask : sfr
    task automatic move(input logic w, wide, input logic [7:0] idx, d,
                        input logic [9:0] exp);
        int i;
        notes.push_back(exp);
        @(posedge CORE_CLK);
        MX_REQ <= 1'b1;
        MX_WRITE <= w;
        MX_WIDE <= wide;
        MX_INDEX <= idx;
        MX_WDATA <= d;
        @(posedge CORE_CLK);
        MX_REQ <= 1'b0;
        for (i = 0; i < 40 && MX_DONE !== 1'b1; i++) @(posedge CORE_CLK);
        if (i == 40) begin
            fail_count++;
            conclude();
        end
    endtask : move
    always @(posedge CORE_CLK) begin
        rd_d <= SFR_RD;
        if (rd_d) check("register read", {2'b00, SFR_RDATA});
        if (MX_DONE === 1'b1)
            check("move", {FL_WR, FL_ERASE, MX_RDATA});
        // Every flash pulse carries scratch flag, address and data
        if (FL_WR === 1'b1 || FL_ERASE === 1'b1) begin
            fl_exp = fl_notes.pop_front();
            comparisons++;
            if (fl_exp !== {FL_SCRATCH, FL_ADDR, FL_WDATA}) begin
                fail_count++;
                $display("[FAIL] flash access expected %h seen %h", fl_exp,
                         {FL_SCRATCH, FL_ADDR, FL_WDATA});
            end
        end
    end
    initial begin
        repeat (10) @(posedge CORE_CLK);
        RST <= 1'b0;
        sfr(1, MAS_ADDR_FLASH_TIMING_CONTROL_REG, 8'h80);
        sfr(1, MAS_ADDR_PROGRAM_STORE_CONTROL_REG, 8'h00);
        sfr(1, MAS_ADDR_CFG_REG, 8'h03);
        sfr(0, MAS_ADDR_FLASH_TIMING_CONTROL_REG, 8'hFF);
        sfr(1, MAS_ADDR_FLASH_TIMING_CONTROL_REG, 8'hC1);
        sfr(0, MAS_ADDR_PROGRAM_STORE_CONTROL_REG, 8'hF9);
        sfr(1, MAS_ADDR_PROGRAM_STORE_CONTROL_REG, 8'h01);
        sfr(1, 8'h00, 8'h00);
        sfr(0, MAS_ADDR_DPH_REG, 8'h40);
        // Page is erased before the byte is programmed
        sfr(0, MAS_ADDR_PROGRAM_STORE_CONTROL_REG, 8'h03);
        fl_notes.push_back({1'b0, 16'h4000, 8'h00});
        move(1, 1, 8'h00, 8'h00, {2'b01, last});
        sfr(0, MAS_ADDR_PROGRAM_STORE_CONTROL_REG, 8'h01);
        fl_notes.push_back({1'b0, 16'h4000, 8'h5A});
        move(1, 1, 8'h00, 8'h5A, {2'b10, last});
        sfr(0, MAS_ADDR_FLASH_TIMING_CONTROL_REG, 8'h00);
        move(1, 1, 8'h00, 8'h5A, {2'b00, last});
        sfr(0, MAS_ADDR_FLASH_TIMING_CONTROL_REG, 8'h01);
        sfr(0, MAS_ADDR_PROGRAM_STORE_CONTROL_REG, 8'h03);
        sfr(0, MAS_ADDR_DPH_REG, 8'hFE);
        move(1, 1, 8'h00, 8'h00, {2'b00, last});
        // Scratchpad keeps only the low seven address bits
        sfr(0, MAS_ADDR_PROGRAM_STORE_CONTROL_REG, 8'h05);
        fl_notes.push_back({1'b1, 16'h0000, 8'h3C});
        move(1, 1, 8'h00, 8'h3C, {2'b10, last});
        sfr(0, MAS_ADDR_PROGRAM_STORE_CONTROL_REG, 8'h00);
        sfr(0, MAS_ADDR_CFG_REG, 8'h00);
        sfr(0, MAS_ADDR_DPH_REG, 8'h12);
        sfr(0, MAS_ADDR_DPL_REG, 8'h34);
        seed = xs(seed);
        v = seed[7:0];
        move(1, 1, 8'h00, v, {2'b00, last});
        sfr(0, MAS_ADDR_PAGE_REG, 8'h02);
        move(0, 0, 8'h34, 8'h00, {2'b00, v});
        last = v;
        // Lower bank, off-chip only mode with multiplexed address and data
        sfr(0, MAS_ADDR_CFG_REG, 8'h0C);
        seed = xs(seed);
        v = seed[7:0];
        move(1, 0, seed[15:8], v, {2'b00, last});
        move(0, 0, seed[15:8], 8'h00, {2'b00, v});
        repeat (3) @(posedge CORE_CLK);
        conclude();
    end
endmodule : mas_top_tb
